// ---- logic/csap_pkg.sv ----
/*
 * Constants, register map and types of the codec serial audio port.
 * Assumes a control interface that presents register index, write data
 * and a write strobe on the core clock.
 */
package csap_pkg;

	// Register indices on the control interface.
	localparam logic [7:0] ADDR_SERIAL_FORMAT = 8'h04;
	localparam logic [7:0] ADDR_COMPANDING = 8'h05;
	localparam logic [7:0] ADDR_CLOCK_GEN = 8'h06;
	localparam logic [7:0] ADDR_PLAYBACK_CTL = 8'h15;
	localparam logic [7:0] ADDR_RECORD_CTL = 8'h19;
	localparam logic [7:0] ADDR_PORT_STATUS = 8'h1A;

	// Field positions in the serial format control register.
	localparam int FMT_LSB = 0;
	localparam int WL_LSB = 2;
	localparam int FRAME_POL_BIT = 4;
	localparam int BIT_CLOCK_INVERT_BIT = 5;
	localparam int PLAY_LEFT_SRC_BIT = 6;
	localparam int PLAY_RIGHT_SRC_BIT = 7;
	localparam int REC_LEFT_SRC_BIT = 8;
	localparam int REC_RIGHT_SRC_BIT = 9;

	// Field positions in the companding control register.
	localparam int REC_LAW_BIT = 0;
	localparam int REC_COMP_BIT = 1;
	localparam int PLAY_LAW_BIT = 2;
	localparam int PLAY_COMP_BIT = 3;

	// Field positions in clock, invert and status registers.
	localparam int MASTER_BIT = 0;
	localparam int BCLK_DIV_LSB = 1;
	localparam int LEFT_INV_BIT = 0;
	localparam int RIGHT_INV_BIT = 1;
	localparam int OVERRUN_BIT = 0;
	localparam int PLAY_PENDING_BIT = 1;

	// Reset values and writable bit masks.
	localparam logic [15:0] SERIAL_FORMAT_RST = 16'h028A;
	localparam logic [15:0] COMPANDING_RST = 16'h0000;
	localparam logic [15:0] CLOCK_GEN_RST = 16'h0006;
	localparam logic [15:0] INVERT_RST = 16'h0000;
	localparam logic [15:0] SERIAL_FORMAT_MASK = 16'h03FF;
	localparam logic [15:0] COMPANDING_MASK = 16'h000F;
	localparam logic [15:0] CLOCK_GEN_MASK = 16'h000F;
	localparam logic [15:0] INVERT_MASK = 16'h0003;

	// Frame geometry in master mode, buffer sizes and synchroniser count.
	localparam logic [5:0] FRAME_BCLKS_LAST = 6'h3F;
	localparam int CHANNEL_BCLK_BIT = 5;
	localparam int SAMPLE_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int SYNC_STAGES = 3;

	// Framing formats.
	typedef enum logic [1:0] {
		FMT_RESERVED = 2'b00,
		FMT_LEFT_JUST = 2'b01,
		FMT_I2S = 2'b10,
		FMT_DSP = 2'b11
	} csap_framing_t;

	// Serial word lengths.
	typedef enum logic [1:0] {
		WL_16 = 2'b00,
		WL_20 = 2'b01,
		WL_24 = 2'b10,
		WL_32 = 2'b11
	} csap_word_len_t;

endpackage

// ---- logic/csap_serial_port.sv ----
/*
 * Serial audio port of a stereo codec with its playback buffer.
 * Assumes one core clock (mclk), a synchronous active-low reset and a
 * control interface that writes register indices with a strobe.
 */
`timescale 1ns/1ps

// Playback buffer: memory of DEPTH words plus one output holding stage.
module csap_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];      // Buffered words.
	logic [AW-1:0]    wrPtr_q;          // Next write slot.
	logic [AW-1:0]    rdPtr_q;          // Next read slot.
	logic [AW:0]      count_q;          // Words held in memory.
	logic             outValid_q;       // Output stage full.
	logic [WIDTH-1:0] outData_q;        // Output stage word.
	logic             push;             // Word accepted this cycle.
	logic             pop;              // Word moved to output stage.

	// Full only when the memory really holds DEPTH words.
	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign push = inValid & inReady;
	assign pop = (count_q != '0) & (~outValid_q | outReady);
	assign outValid = outValid_q;
	assign outData = outData_q;

	// Memory write side.
	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wrPtr_q] <= inData;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end

	// Output stage; it only empties when the drain side accepts.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			outValid_q <= 1'b0;
			outData_q <= '0;
		end
		else if (pop)
		begin
			outValid_q <= 1'b1;
			outData_q <= mem[rdPtr_q];
		end
		else if (outReady)
		begin
			outValid_q <= 1'b0;
		end
	end
endmodule

// Port engine: registers, clock master, framing, companding, routing.
module csap_serial_port (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	input  wire logic        bitClockIn,
	output logic             bitClockOut,
	output logic             bitClockOe,
	input  wire logic        frameClockIn,
	output logic             frameClockOut,
	output logic             frameClockOe,
	input  wire logic        playSerialIn,
	output logic             recSerialOut,
	input  wire logic [31:0] recLeft,
	input  wire logic [31:0] recRight,
	output logic             recTake,
	output logic             playValid,
	input  wire logic        playReady,
	output logic      [31:0] playLeft,
	output logic      [31:0] playRight
);
	// Half period minus one, in core clocks, for a divider code.
	function automatic logic [3:0] halfLast(input logic [2:0] code);
		case (code)
			3'h0, 3'h1: halfLast = 4'h0;
			3'h2: halfLast = 4'h1;
			3'h3: halfLast = 4'h3;
			3'h4: halfLast = 4'h7;
			default: halfLast = 4'hF;
		endcase
	endfunction

	// Bits per word; eight when the path is in 8-bit mode.
	function automatic logic [5:0] wordBits(input logic [1:0] wl,
		input logic eight);
		if (eight)
			wordBits = 6'd8;
		else
		case (wl)
			csap_pkg::WL_16: wordBits = 6'd16;
			csap_pkg::WL_20: wordBits = 6'd20;
			csap_pkg::WL_24: wordBits = 6'd24;
			default: wordBits = 6'd32;
		endcase
	endfunction

	// Slot decode: {valid, right channel, bit index within word}.
	function automatic logic [6:0] slotOf(input logic [6:0] pos,
		input logic [6:0] off, input logic [5:0] wl, input logic dsp,
		input logic chanRight, input logic en);
		logic [6:0] r;
		r = pos - off;
		slotOf = 7'h00;
		if (en && pos >= off)
		begin
			if (!dsp && r < {1'b0, wl})
				slotOf = {1'b1, chanRight, r[4:0]};
			else if (dsp && r < {1'b0, wl})
				slotOf = {2'b10, r[4:0]};
			else if (dsp && r < {wl, 1'b0})
				slotOf = {2'b11, 5'(r - {1'b0, wl})};
		end
	endfunction

	// Mu-law compression of a 13-bit sample, code inverted.
	function automatic logic [7:0] muEnc(input logic [12:0] s);
		logic [11:0] mag;
		logic [13:0] x;
		logic [2:0]  e;
		mag = s[12] ? ~s[11:0] : s[11:0];
		x = {1'b0, mag, 1'b0} + 14'd33;
		if (x[13])
			x = 14'h1FFF;
		e = 3'd0;
		for (int i = 1; i < 8; i++)
			if (x[i+5])
				e = 3'(i);
		muEnc = ~{s[12], e, 4'(x >> ({1'b0, e} + 4'd1))};
	endfunction

	// A-law compression of a 12-bit sample, even bits inverted.
	function automatic logic [7:0] aEnc(input logic [11:0] s);
		logic [10:0] mag;
		logic [2:0]  e;
		mag = s[11] ? ~s[10:0] : s[10:0];
		e = 3'd0;
		for (int i = 1; i < 8; i++)
			if (mag[i+3])
				e = 3'(i);
		aEnc = {~s[11], e, (e == 3'd0) ? mag[3:0] :
			4'(mag >> (e - 3'd1))} ^ 8'h55;
	endfunction

	// Expansion of an 8-bit code back to a left-aligned sample.
	function automatic logic [31:0] expand(input logic [7:0] c,
		input logic aLaw);
		logic [7:0]  d;
		logic [15:0] t;
		logic [12:0] a;
		if (aLaw)
		begin
			d = c ^ 8'h55;
			a = (d[6:4] == 3'd0) ? {8'd0, d[3:0], 1'b1} :
				13'({8'd1, d[3:0], 1'b1} << (d[6:4] - 3'd1));
			t = 16'h0000;
			expand = {d[7] ? a : 13'(-a), 19'd0};
		end
		else
		begin
			d = ~c;
			a = 13'h0000;
			t = 16'((({8'd0, d[3:0], 3'd0} + 16'h0084) << d[6:4])
				- 16'h0084);
			expand = {d[7] ? 16'(-t) : t, 16'd0};
		end
	endfunction

	logic [15:0] fmtCtl_q;      // Serial format control.
	logic [15:0] compCtl_q;     // Companding control.
	logic [15:0] clkCtl_q;      // Clock generation control.
	logic [15:0] playCtl_q;     // Playback channel invert bits.
	logic [15:0] recCtl_q;      // Record channel invert bits.
	logic        overrun_q;     // Sticky: playback pair dropped.
	logic [2:0]  sync1_q;       // First synchroniser stage.
	logic [2:0]  sync2_q;       // Second synchroniser stage.
	logic [2:0]  sync3_q;       // Third synchroniser stage.
	logic [2:0]  filt_q;        // Accepted pin levels.
	logic [3:0]  halfCnt_q;     // Master half period counter.
	logic        mBclk_q;       // Master bit clock, effective polarity.
	logic [5:0]  mBitCnt_q;     // Master bit clock count within frame.
	logic        mLr_q;         // Master frame clock, pin level.
	logic        prevBclk_q;    // Bit clock one cycle ago.
	logic        prevLr_q;      // Frame clock one cycle ago.
	logic [6:0]  posCnt_q;      // Rising edges since frame event.
	logic [31:0] txL_q;         // Left word being sent.
	logic [31:0] txR_q;         // Right word being sent.
	logic [31:0] shift_q;       // Received bits.
	logic [31:0] rxL_q;         // Received left word, expanded.
	logic        pushValid_q;   // Pair offered to the buffer.
	logic [63:0] pushData_q;    // Routed, inverted playback pair.
	logic        fifoReady;     // Buffer can take a pair.

	logic        master;        // Port drives the clocks.
	logic        dsp;           // DSP/PCM framing.
	logic        pol;           // Frame polarity or DSP variant.
	logic        bInv;          // Bit clock invert.
	logic        effBclk;       // Bit clock, sampling edge rising.
	logic        rawLr;         // Frame clock pin level.
	logic        bitRise;       // Sampling edge.
	logic        bitFall;       // Launch edge.
	logic        frameEvt;      // Frame clock event.
	logic        chanRight;     // Right half in LJ and I2S.
	logic        loadEvt;       // Start of a new stereo frame.
	logic [6:0]  nextPos;       // Position of the coming rising edge.
	logic [6:0]  firstPos;      // Position of the first MSB.
	logic        fmtOk;         // Framing code is not reserved.
	logic        playComp;      // Playback companding enabled.
	logic        recComp;       // Record companding enabled.
	logic [5:0]  playWl;        // Playback word bits.
	logic [5:0]  recWl;         // Record word bits.
	logic [6:0]  txSlot;        // Slot of the bit being launched.
	logic [6:0]  rxSlot;        // Slot of the bit being sampled.
	logic [31:0] adcL;          // Inverted left record sample.
	logic [31:0] adcR;          // Inverted right record sample.
	logic [31:0] slotL;         // Routed left slot word.
	logic [31:0] slotR;         // Routed right slot word.
	logic [31:0] curL;          // Left word for the coming bit.
	logic [31:0] curR;          // Right word for the coming bit.
	logic [31:0] rxWord;        // Completed word, left aligned.
	logic [31:0] rxExp;         // Completed word after expansion.
	logic [31:0] dacL;          // Routed left DAC word.
	logic [31:0] dacR;          // Routed right DAC word.

	assign master = clkCtl_q[csap_pkg::MASTER_BIT];
	assign dsp = (fmtCtl_q[csap_pkg::FMT_LSB +: 2] == csap_pkg::FMT_DSP);
	assign fmtOk = (fmtCtl_q[csap_pkg::FMT_LSB +: 2]
		!= csap_pkg::FMT_RESERVED);
	assign pol = fmtCtl_q[csap_pkg::FRAME_POL_BIT];
	assign bInv = fmtCtl_q[csap_pkg::BIT_CLOCK_INVERT_BIT];
	assign playComp = compCtl_q[csap_pkg::PLAY_COMP_BIT];
	assign recComp = compCtl_q[csap_pkg::REC_COMP_BIT];
	// Eight bit mode: companding on, or a law bit set with both off.
	assign playWl = wordBits(fmtCtl_q[csap_pkg::WL_LSB +: 2],
		playComp | (compCtl_q[csap_pkg::PLAY_LAW_BIT] & ~recComp));
	assign recWl = wordBits(fmtCtl_q[csap_pkg::WL_LSB +: 2],
		recComp | (compCtl_q[csap_pkg::REC_LAW_BIT] & ~playComp));

	// Clock source: own generator or filtered pins.
	assign effBclk = master ? mBclk_q : (filt_q[0] ^ bInv);
	assign rawLr = master ? mLr_q : filt_q[1];
	assign bitRise = effBclk & ~prevBclk_q;
	assign bitFall = ~effBclk & prevBclk_q;
	// DSP frames start on a rising frame edge; others on any change.
	assign frameEvt = dsp ? (rawLr & ~prevLr_q) : (rawLr ^ prevLr_q);
	assign chanRight = rawLr ^ pol;
	assign loadEvt = frameEvt & (dsp | ~chanRight);
	assign nextPos = frameEvt ? 7'd0 : posCnt_q;
	// I2S and DSP mode A put the MSB one edge late.
	assign firstPos = (fmtCtl_q[csap_pkg::FMT_LSB +: 2] == csap_pkg::FMT_I2S
		|| (dsp && !pol)) ? 7'd1 : 7'd0;
	assign txSlot = slotOf(nextPos, firstPos, recWl, dsp, chanRight, fmtOk);
	assign rxSlot = slotOf(posCnt_q, firstPos, playWl, dsp, chanRight, fmtOk);

	// Record data: invert, route, then compress into the top byte.
	assign adcL = recLeft ^ {32{recCtl_q[csap_pkg::LEFT_INV_BIT]}};
	assign adcR = recRight ^ {32{recCtl_q[csap_pkg::RIGHT_INV_BIT]}};
	always_comb
	begin
		slotL = fmtCtl_q[csap_pkg::REC_LEFT_SRC_BIT] ? adcR : adcL;
		slotR = fmtCtl_q[csap_pkg::REC_RIGHT_SRC_BIT] ? adcR : adcL;
		if (recComp)
		begin
			// Code in the eight MSBs, rest zero.
			slotL = {compCtl_q[csap_pkg::REC_LAW_BIT] ? aEnc(slotL[31:20]) :
				muEnc(slotL[31:19]), 24'd0};
			slotR = {compCtl_q[csap_pkg::REC_LAW_BIT] ? aEnc(slotR[31:20]) :
				muEnc(slotR[31:19]), 24'd0};
		end
		curL = loadEvt ? slotL : txL_q;
		curR = loadEvt ? slotR : txR_q;
	end

	// Received word, left aligned, expanded when companding is on.
	assign rxWord = {shift_q[30:0], filt_q[2]} << (6'd32 - playWl);
	assign rxExp = playComp ? expand(rxWord[31:24],
		compCtl_q[csap_pkg::PLAY_LAW_BIT]) : rxWord;
	always_comb
	begin
		dacL = fmtCtl_q[csap_pkg::PLAY_LEFT_SRC_BIT] ? rxExp : rxL_q;
		dacR = fmtCtl_q[csap_pkg::PLAY_RIGHT_SRC_BIT] ? rxExp : rxL_q;
		dacL = dacL ^ {32{playCtl_q[csap_pkg::LEFT_INV_BIT]}};
		dacR = dacR ^ {32{playCtl_q[csap_pkg::RIGHT_INV_BIT]}};
	end

	// Register writes; unmapped indices are ignored.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			fmtCtl_q <= csap_pkg::SERIAL_FORMAT_RST;
			compCtl_q <= csap_pkg::COMPANDING_RST;
			clkCtl_q <= csap_pkg::CLOCK_GEN_RST;
			playCtl_q <= csap_pkg::INVERT_RST;
			recCtl_q <= csap_pkg::INVERT_RST;
		end
		else if (regWrEn)
		begin
			if (regAddr == csap_pkg::ADDR_SERIAL_FORMAT)
				fmtCtl_q <= regWrData & csap_pkg::SERIAL_FORMAT_MASK;
			else if (regAddr == csap_pkg::ADDR_COMPANDING)
				compCtl_q <= regWrData & csap_pkg::COMPANDING_MASK;
			else if (regAddr == csap_pkg::ADDR_CLOCK_GEN)
				clkCtl_q <= regWrData & csap_pkg::CLOCK_GEN_MASK;
			else if (regAddr == csap_pkg::ADDR_PLAYBACK_CTL)
				playCtl_q <= regWrData & csap_pkg::INVERT_MASK;
			else if (regAddr == csap_pkg::ADDR_RECORD_CTL)
				recCtl_q <= regWrData & csap_pkg::INVERT_MASK;
		end
	end

	// Registered read data, one cycle after the index.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			regRdData <= 16'h0000;
		else if (regAddr == csap_pkg::ADDR_SERIAL_FORMAT)
			regRdData <= fmtCtl_q;
		else if (regAddr == csap_pkg::ADDR_COMPANDING)
			regRdData <= compCtl_q;
		else if (regAddr == csap_pkg::ADDR_CLOCK_GEN)
			regRdData <= clkCtl_q;
		else if (regAddr == csap_pkg::ADDR_PLAYBACK_CTL)
			regRdData <= playCtl_q;
		else if (regAddr == csap_pkg::ADDR_RECORD_CTL)
			regRdData <= recCtl_q;
		else if (regAddr == csap_pkg::ADDR_PORT_STATUS)
			regRdData <= {14'd0, playValid, overrun_q};
		else
			regRdData <= 16'h0000;
	end

	// Overrun flag; a new drop wins over a write-one clear.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			overrun_q <= 1'b0;
		else if (pushValid_q & ~fifoReady)
			overrun_q <= 1'b1;
		else if (regWrEn && regAddr == csap_pkg::ADDR_PORT_STATUS
			&& regWrData[csap_pkg::OVERRUN_BIT])
			overrun_q <= 1'b0;
	end

	// Three-stage synchronisers; a level counts once stages 2 and 3 agree.
	for (genvar i = 0; i < csap_pkg::SYNC_STAGES; i++)
	begin : g_sync
		always_ff @(posedge mclk)
		begin
			if (!nrst)
			begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
				sync3_q[i] <= 1'b0;
				filt_q[i] <= 1'b0;
			end
			else
			begin
				sync1_q[i] <= (i == 0) ? bitClockIn :
					(i == 1) ? frameClockIn : playSerialIn;
				sync2_q[i] <= sync1_q[i];
				sync3_q[i] <= sync2_q[i];
				if (sync2_q[i] == sync3_q[i])
					filt_q[i] <= sync3_q[i];
			end
		end
	end

	// Master clock generator: bit clock from core clock, frame of 64.
	always_ff @(posedge mclk)
	begin
		if (!nrst || !master)
		begin
			halfCnt_q <= 4'h0;
			mBclk_q <= 1'b0;
			mBitCnt_q <= csap_pkg::FRAME_BCLKS_LAST;
			mLr_q <= pol & ~dsp;
		end
		else if (halfCnt_q >= halfLast(clkCtl_q[csap_pkg::BCLK_DIV_LSB +: 3]))
		begin
			halfCnt_q <= 4'h0;
			mBclk_q <= ~mBclk_q;
			if (mBclk_q)
			begin
				// Frame clock moves on the launch edge only.
				mBitCnt_q <= mBitCnt_q + 6'd1;
				if (dsp)
					mLr_q <= (mBitCnt_q == csap_pkg::FRAME_BCLKS_LAST);
				else
					mLr_q <= (mBitCnt_q + 6'd1)
						>> csap_pkg::CHANNEL_BCLK_BIT != 6'd0 ? ~pol : pol;
			end
		end
		else
		begin
			halfCnt_q <= halfCnt_q + 4'h1;
		end
	end

	// Pin drivers: clocks are outputs only in master mode.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			bitClockOut <= 1'b0;
			frameClockOut <= 1'b0;
			bitClockOe <= 1'b0;
			frameClockOe <= 1'b0;
		end
		else
		begin
			bitClockOut <= mBclk_q ^ bInv;
			frameClockOut <= mLr_q;
			bitClockOe <= master;
			frameClockOe <= master;
		end
	end

	// Edge history and slot position counter.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			prevBclk_q <= 1'b0;
			prevLr_q <= 1'b0;
			posCnt_q <= 7'h7F;
		end
		else
		begin
			prevBclk_q <= effBclk;
			prevLr_q <= rawLr;
			if (frameEvt)
				posCnt_q <= 7'd0;
			else if (bitRise && posCnt_q != 7'h7F)
				posCnt_q <= posCnt_q + 7'd1;
		end
	end

	// Transmit: load words at frame start, launch bits MSB first.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			txL_q <= 32'h0000_0000;
			txR_q <= 32'h0000_0000;
			recTake <= 1'b0;
			recSerialOut <= 1'b0;
		end
		else
		begin
			recTake <= loadEvt;
			if (loadEvt)
			begin
				txL_q <= slotL;
				txR_q <= slotR;
			end
			if (bitFall | frameEvt)
			begin
				if (txSlot[6])
					recSerialOut <= txSlot[5] ?
						curR[5'd31 - txSlot[4:0]] : curL[5'd31 - txSlot[4:0]];
				else
					recSerialOut <= 1'b0;
			end
		end
	end

	// Receive: shift data bits in on sampling edges of used slots.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			shift_q <= 32'h0000_0000;
			rxL_q <= 32'h0000_0000;
			pushValid_q <= 1'b0;
			pushData_q <= 64'h0;
		end
		else
		begin
			pushValid_q <= 1'b0;
			if (bitRise && !frameEvt && rxSlot[6])
			begin
				shift_q <= {shift_q[30:0], filt_q[2]};
				if ({1'b0, rxSlot[4:0]} == playWl - 6'd1 && !rxSlot[5])
					rxL_q <= rxExp;
				else if ({1'b0, rxSlot[4:0]} == playWl - 6'd1)
				begin
					pushValid_q <= 1'b1;
					pushData_q <= {dacL, dacR};
				end
			end
		end
	end

	// Playback pairs wait here for the drain side.
	csap_fifo #(
		.WIDTH (2 * csap_pkg::SAMPLE_W),
		.DEPTH (csap_pkg::FIFO_DEPTH)
	) u_play_fifo (
		.mclk     (mclk),
		.nrst     (nrst),
		.inValid  (pushValid_q),
		.inData   (pushData_q),
		.inReady  (fifoReady),
		.outValid (playValid),
		.outData  ({playLeft, playRight}),
		.outReady (playReady)
	);
endmodule

// ---- sim/csap_serial_port_sva.sv ----
/* Assertions on the serial port top level.
   Sees only the top ports; clock mclk, reset nrst. */
`timescale 1ns/1ps
module csap_port_sva (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  regAddr,
	input wire logic        regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic        bitClockOe,
	input wire logic        frameClockOe,
	input wire logic        recTake,
	input wire logic        playValid,
	input wire logic        playReady,
	input wire logic [31:0] playLeft
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// A write then a read of one register returns the masked value.
	property p_wr_rd(logic [7:0] a, logic [15:0] m);
		regWrEn && regAddr == a ##1 !regWrEn && regAddr == a
		|=> regRdData == ($past(regWrData, 2) & m);
	endproperty
	a_reset_quiet: assert property (disable iff (1'b0)
		!nrst |=> !bitClockOe && !frameClockOe && regRdData == 16'h0000)
		else $error("port not idle after reset");
	a_format_rd: assert property (p_wr_rd(8'h04, 16'h03FF))
		else $error("format readback wrong");
	a_compand_rd: assert property (p_wr_rd(8'h05, 16'h000F))
		else $error("companding readback wrong");
	a_clock_rd: assert property (p_wr_rd(8'h06, 16'h000F))
		else $error("clock readback wrong");
	a_play_inv: assert property (p_wr_rd(8'h15, 16'h0003))
		else $error("playback invert readback wrong");
	a_rec_inv: assert property (p_wr_rd(8'h19, 16'h0003))
		else $error("record invert readback wrong");
	a_clocks_paired: assert property (bitClockOe == frameClockOe)
		else $error("clock enables differ");
	a_master_drive: assert property (
		regWrEn && regAddr == 8'h06 && regWrData[0] |-> ##[1:4] bitClockOe)
		else $error("master write did not drive clocks");
	a_slave_input: assert property (
		regWrEn && regAddr == 8'h06 && !regWrData[0] |-> ##[1:4] !bitClockOe)
		else $error("slave write did not release clocks");
	a_take_pulse: assert property (recTake |=> !recTake)
		else $error("frame take longer than one cycle");
	a_play_hold: assert property (
		playValid && !playReady |=> playValid && $stable(playLeft))
		else $error("playback word changed before taken");
	cover property (bitClockOe && recTake);
	cover property (playValid && playReady);
	cover property (regWrEn && regAddr == 8'h19);
endmodule
bind csap_serial_port csap_port_sva chk_u (.*);

// ---- sim/csap_host_model.sv ----
/* Host serial master: makes bit and frame clocks, sends playback words
   and collects record words in left-justified framing, 32-bit words. */
`timescale 1ns/1ps
module csap_host_model #(
	parameter int HALF = 8
) (
	input  wire logic        mclk,
	input  wire logic        run,
	input  wire logic [63:0] pattern,
	output logic             bitClock,
	output logic             frameClock,
	output logic             serialOut,
	input  wire logic        serialIn,
	output logic      [63:0] captured
);
	// One whole frame per pass while run is high; clocks stand still after.
	initial
	begin
		{bitClock, serialOut, captured} = '0;
		frameClock = 1'b1;
		forever
		begin
			@(posedge mclk);
			if (run)
			begin
				for (int i = 0; i < 64; i++)
				begin
					// Frame and data change on the falling edge.
					// High half, taken as a DSP pulse, rises 32 bits late.
					frameClock <= (i >= 32);
					serialOut <= pattern[63 - i];
					bitClock <= 1'b0;
					repeat (HALF) @(posedge mclk);
					bitClock <= 1'b1;
					captured <= {captured[62:0], serialIn};
					repeat (HALF) @(posedge mclk);
				end
				// Released data line shows the inverse of its last bit.
				bitClock <= 1'b0;
				serialOut <= ~serialOut;
			end
		end
	end
endmodule

// ---- sim/test_csap_serial_port.sv ----
/* Self-checking bench: registers, master clock rates, overrun and
   slave transfers against the host model. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
	$display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module test_csap_serial_port;
	logic        mclk, nrst, regWrEn, playReady, run, hBclk, hFrame;
	logic        bitClockOut, bitClockOe, frameClockOut, frameClockOe;
	logic        playSerialIn, recSerialOut, recTake, playValid;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, v;
	logic [31:0] recLeft, recRight, playLeft, playRight;
	logic [63:0] pattern, captured;
	int          bad_count, tests_run;
	logic [7:0]  adr [5] = '{8'h04, 8'h05, 8'h06, 8'h15, 8'h19};
	logic [15:0] rv [5] = '{16'h028A, 16'h0, 16'h0006, 16'h0, 16'h0};
	logic [15:0] wm [5] = '{16'h03FF, 16'h000F, 16'h000F, 16'h3, 16'h3};
	// Pin level is the port's drive when enabled, else the host's.
	wire logic bitClockIn = bitClockOe ? bitClockOut : hBclk;
	wire logic frameClockIn = frameClockOe ? frameClockOut : hFrame;
	csap_serial_port dut_u (.*);
	csap_host_model #(.HALF(8)) host_u (.mclk(mclk), .run(run),
		.pattern(pattern), .bitClock(hBclk), .frameClock(hFrame),
		.serialOut(playSerialIn), .serialIn(recSerialOut),
		.captured(captured));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task tick;
		@(posedge mclk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick;
		regWrEn = 1'b0;
		// One idle edge drops the strobe between back-to-back writes.
		tick;
	endtask
	task rd(input logic [7:0] a);
		regAddr = a;
		tick;
		v = regRdData;
	endtask
	// Counts core cycles between two rising edges of a master clock.
	task gap(input logic sel, input int ex);
		int e;
		int c;
		logic p;
		e = 0;
		c = 0;
		p = 1'b1;
		for (int k = 0; k < 5000 && e < 2; k++)
		begin
			tick;
			if ((sel ? frameClockOut : bitClockOut) && !p) e++;
			if (e == 1) c++;
			p = sel ? frameClockOut : bitClockOut;
		end
		`CHK("period", ex, c)
	endtask
	task xfer(input logic [15:0] fmt, inv, input logic [63:0] er, ep);
		playReady = 1'b1;
		repeat (40) tick;
		playReady = 1'b0;
		wr(8'h04, fmt);
		wr(8'h15, inv);
		wr(8'h19, inv);
		run = 1'b1;
		repeat (1100) tick;
		run = 1'b0;
		repeat (1100) tick;
		`CHK("record", er, captured)
		`CHK("playback", ep, {playLeft, playRight})
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		{nrst, regWrEn, playReady, run, regAddr, regWrData} = '0;
		recLeft = 32'hA5C3_0F81;
		recRight = 32'h1E2D_3C4B;
		pattern = 64'hC3A5_9617_0F1E_2D3C;
		repeat (2) tick;
		nrst = 1'b1;
		repeat (4) tick;
		for (int n = 0; n < 5; n++)
		begin
			rd(adr[n]);
			`CHK("reset value", rv[n], v)
			wr(adr[n], 16'hFFFF);
			rd(adr[n]);
			`CHK("write mask", wm[n], v)
			wr(adr[n], rv[n]);
		end
		wr(8'h33, 16'hFFFF);
		rd(8'h33);
		`CHK("unmapped", 16'h0000, v)
		for (int k = 1; k < 6; k++)
		begin
			wr(8'h06, 16'(2 * k + 1));
			gap(1'b0, 1 << k);
		end
		gap(1'b1, 64 << 5);
		wr(8'h06, 16'h0003);
		repeat (4500) tick;
		rd(8'h1A);
		`CHK("overrun", 16'h0003, v)
		wr(8'h06, 16'h0006);
		// Let the last fed-back master edges die out before clearing.
		repeat (8) tick;
		wr(8'h1A, 16'h0001);
		xfer(16'h028D, 16'h0, {recLeft, recRight}, pattern);
		xfer(16'h028D, 16'h3, ~{recLeft, recRight}, ~pattern);
		xfer(16'h014D, 16'h0, {recRight, recLeft},
			{pattern[31:0], pattern[63:32]});
		rd(8'h1A);
		`CHK("status", 16'h0002, v)
		// Mid-run reset sets the slot count to 7'h7F, then a DSP mode B transfer.
		nrst = 1'b0;
		repeat (2) tick;
		nrst = 1'b1;
		repeat (4) tick;
		xfer(16'h029F, 16'h0, {recRight, recLeft},
			{pattern[31:0], pattern[63:32]});
		give_verdict;
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		give_verdict;
	end
endmodule
